// ==== metering_pkg.sv ====
// package: register map, mode fields, timing and carrier types for the metering register bank
`default_nettype none
package metering_pkg;
   localparam int unsigned DATA_W = 24;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_CURRENT_AC_TRIM = 6'h10;
   localparam logic [5:0] IDX_VOLTAGE_AC_TRIM = 6'h11;
   localparam logic [5:0] IDX_OPERATING_CONFIG = 6'h12;
   localparam logic [5:0] IDX_TEMPERATURE_READING = 6'h13;
   localparam logic [5:0] IDX_AVG_REACTIVE_POWER = 6'h14;
   localparam logic [5:0] IDX_INST_REACTIVE_POWER = 6'h15;
   localparam logic [5:0] IDX_CURRENT_MAX_SAMPLE = 6'h16;
   localparam logic [5:0] IDX_VOLTAGE_MAX_SAMPLE = 6'h17;
   localparam logic [5:0] IDX_STATUS = 6'h20;
   localparam logic [5:0] IDX_COMMAND = 6'h21;
   localparam logic [5:0] IDX_CYCLE_COUNT = 6'h22;
   // reset values
   localparam logic [23:0] TRIM_RESET = 24'h000000;
   localparam logic [23:0] CONFIG_RESET = 24'h000000;
   localparam logic [23:0] CYCLE_COUNT_RESET = 24'h000fa0;
   // operating_config field positions
   localparam int unsigned BIT_AUTO_LINE_FREQ_TRACK = 0;
   localparam int unsigned BIT_POSITIVE_ONLY = 1;
   localparam int unsigned BIT_PULSE_OUT_C_LO = 2;
   localparam int unsigned BIT_COMP_FILTER_DISABLE = 4;
   localparam int unsigned BIT_VOLTAGE_DC_BLOCK = 5;
   localparam int unsigned BIT_CURRENT_DC_BLOCK = 6;
   localparam int unsigned BIT_CURRENT_EXTRA_DELAY = 7;
   localparam int unsigned BIT_VOLTAGE_EXTRA_DELAY = 8;
   localparam int unsigned BIT_PULSE_OUT_B_SELECT = 9;
   // status and command bits
   localparam int unsigned BIT_CALC_DONE_FLAG = 23;
   localparam int unsigned BIT_CMD_AC_CAL = 0;
   // calibration length: 6n + 30 sample cycles
   localparam int unsigned CAL_MULT = 6;
   localparam int unsigned CAL_EXTRA = 30;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      PULSE_C_REACTIVE = 2'b00,
      PULSE_C_SUPPLY = 2'b01,
      PULSE_C_VSIGN = 2'b10,
      PULSE_C_APPARENT = 2'b11
   } pulse_c_sel_t;

   // decoded mode field group handed to the signal path
   typedef struct packed {
      logic pulse_out_b_select;
      logic voltage_extra_delay;
      logic current_extra_delay;
      logic current_dc_block;
      logic voltage_dc_block;
      logic current_all_pass;
      logic voltage_all_pass;
      logic comp_filter_enable;
      pulse_c_sel_t pulse_out_c_select;
      logic positive_only;
      logic auto_line_freq_track;
   } path_ctrl_t;

   // one adc sample set (current, voltage, shifted voltage) with its strobe
   typedef struct packed {
      logic valid;
      logic [23:0] current;
      logic [23:0] voltage;
      logic [23:0] voltage_shift;
   } sample_t;
endpackage
`default_nettype wire

// ==== metering_regs.sv ====
// metering mode and result register bank behind an axi4-lite slave
`default_nettype none
module metering_regs
#(
   parameter int unsigned CNT_W = 24
)
(
   input wire logic clk,
   input wire logic rstn,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // sample path from the adc, same clock
   input wire metering_pkg::sample_t sample,
   input wire logic temp_valid,
   input wire logic [23:0] temp_celsius,
   // energy pulse sources
   input wire logic energy_pulse_raw,
   input wire logic energy_negative,
   input wire logic apparent_pulse_raw,
   input wire logic reactive_pulse_raw,
   input wire logic supply_monitor_input,
   output metering_pkg::path_ctrl_t path_ctrl,
   output logic energy_pulse_out_a,
   output logic energy_pulse_out_b,
   output logic energy_pulse_out_c,
   output logic cycle_end
);
   import metering_pkg::*;

   // refuse counter widths that the cycle logic cannot serve
   if (CNT_W < 8 || CNT_W > 24)
   begin
      $error("CNT_W out of range");
   end

   logic [23:0] current_ac_trim_q, voltage_ac_trim_q, config_q, temp_q;
   logic [23:0] avg_q_q, inst_q_q, ipeak_q, vpeak_q, ipeak_run_q, vpeak_run_q;
   logic [23:0] cycle_count_q;
   logic calc_done_q;
   logic [CNT_W-1:0] samp_cnt_q;
   logic [47:0] acc_q;
   logic signed [47:0] ical_acc_q, vcal_acc_q;
   logic cal_busy_q;
   logic [31:0] cal_cnt_q;
   logic [23:0] cur_d1_q, vol_d1_q;

   // axi write channel capture
   logic aw_held_q, w_held_q;
   logic [5:0] aw_idx_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_fire;
   logic ar_ok;
   logic wr_ok;

   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready = !w_held_q && !s_axi_bvalid;
   assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wr_ok = (aw_idx_q inside {IDX_CURRENT_AC_TRIM, IDX_VOLTAGE_AC_TRIM, IDX_OPERATING_CONFIG,
                                    IDX_STATUS, IDX_COMMAND, IDX_CYCLE_COUNT});

   // address and data may arrive in either order
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_idx_q <= 6'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            aw_idx_q <= s_axi_awaddr[7:2];
         end
         else if (wr_fire)
            aw_held_q <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_held_q <= 1'b0;
      end
   end

   // write response, slverr for unmapped or read-only words
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // byte-lane merge for 24-bit registers
   function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [23:0] r;
      r = old;
      for (int b = 0; b < 3; b++)
         if (s[b])
            r[b*8 +: 8] = d[b*8 +: 8];
      return r;
   endfunction

   logic wr_trim_i, wr_trim_v, wr_cfg, wr_stat, wr_cmd, wr_cyc;
   assign wr_trim_i = wr_fire && aw_idx_q == IDX_CURRENT_AC_TRIM;
   assign wr_trim_v = wr_fire && aw_idx_q == IDX_VOLTAGE_AC_TRIM;
   assign wr_cfg = wr_fire && aw_idx_q == IDX_OPERATING_CONFIG;
   assign wr_stat = wr_fire && aw_idx_q == IDX_STATUS;
   assign wr_cmd = wr_fire && aw_idx_q == IDX_COMMAND;
   assign wr_cyc = wr_fire && aw_idx_q == IDX_CYCLE_COUNT;

   // operating config and cycle count
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         config_q <= CONFIG_RESET;
         cycle_count_q <= CYCLE_COUNT_RESET;
      end
      else
      begin
         if (wr_cfg)
            config_q <= merge(config_q, w_data_q, w_strb_q);
         if (wr_cyc)
            cycle_count_q <= merge(cycle_count_q, w_data_q, w_strb_q);
      end
   end

   // computation cycle: n samples, clamped to at least one
   logic [CNT_W-1:0] n_eff;
   assign n_eff = (cycle_count_q[CNT_W-1:0] == '0) ? CNT_W'(1) : cycle_count_q[CNT_W-1:0];
   assign cycle_end = sample.valid && (samp_cnt_q == n_eff - CNT_W'(1)) && !cal_busy_q;

   always_ff @(posedge clk)
   begin
      if (!rstn)
         samp_cnt_q <= '0;
      else if (sample.valid)
         samp_cnt_q <= (samp_cnt_q >= n_eff - CNT_W'(1)) ? '0 : samp_cnt_q + CNT_W'(1);
   end

   // calibration sequencer: runs 6n+30 samples, averages each channel
   logic [31:0] cal_len;
   logic cal_last;
   assign cal_len = 32'(CAL_MULT) * 32'(n_eff) + 32'(CAL_EXTRA);
   assign cal_last = cal_busy_q && sample.valid && cal_cnt_q == cal_len - 32'd1;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         cal_busy_q <= 1'b0;
         cal_cnt_q <= 32'd0;
         ical_acc_q <= '0;
         vcal_acc_q <= '0;
      end
      else if (!cal_busy_q)
      begin
         if (wr_cmd && w_strb_q[0] && w_data_q[BIT_CMD_AC_CAL])
         begin
            cal_busy_q <= 1'b1;
            cal_cnt_q <= 32'd0;
            ical_acc_q <= '0;
            vcal_acc_q <= '0;
         end
      end
      else if (sample.valid)
      begin
         ical_acc_q <= ical_acc_q + 48'(signed'(sample.current));
         vcal_acc_q <= vcal_acc_q + 48'(signed'(sample.voltage));
         cal_cnt_q <= cal_cnt_q + 32'd1;
         if (cal_last)
            cal_busy_q <= 1'b0;
      end
   end

   // trims: signed 1.23 fraction, cleared on reset, loaded by calibration
   logic signed [47:0] ical_mean, vcal_mean;
   assign ical_mean = (ical_acc_q + 48'(signed'(sample.current))) / signed'(48'(cal_len));
   assign vcal_mean = (vcal_acc_q + 48'(signed'(sample.voltage))) / signed'(48'(cal_len));

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         current_ac_trim_q <= TRIM_RESET;
         voltage_ac_trim_q <= TRIM_RESET;
      end
      else if (cal_last)
      begin
         current_ac_trim_q <= 24'(-ical_mean);
         voltage_ac_trim_q <= 24'(-vcal_mean);
      end
      else
      begin
         if (wr_trim_i)
            current_ac_trim_q <= merge(current_ac_trim_q, w_data_q, w_strb_q);
         if (wr_trim_v)
            voltage_ac_trim_q <= merge(voltage_ac_trim_q, w_data_q, w_strb_q);
      end
   end

   // calc done: set wins over a write-one clear
   always_ff @(posedge clk)
   begin
      if (!rstn)
         calc_done_q <= 1'b0;
      else if (cycle_end || cal_last)
         calc_done_q <= 1'b1;
      else if (wr_stat && w_strb_q[2] && w_data_q[BIT_CALC_DONE_FLAG])
         calc_done_q <= 1'b0;
   end

   // one-sample extra delay per channel
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         cur_d1_q <= 24'h000000;
         vol_d1_q <= 24'h000000;
      end
      else if (sample.valid)
      begin
         cur_d1_q <= sample.current;
         vol_d1_q <= sample.voltage_shift;
      end
   end

   logic [23:0] cur_s, volq_s;
   logic signed [47:0] prod;
   assign cur_s = config_q[BIT_CURRENT_EXTRA_DELAY] ? cur_d1_q : sample.current;
   assign volq_s = config_q[BIT_VOLTAGE_EXTRA_DELAY] ? vol_d1_q : sample.voltage_shift;
   assign prod = signed'(cur_s) * signed'(volq_s);

   // magnitude compare on signed samples
   function automatic logic bigger(input logic [23:0] a, input logic [23:0] b);
      logic [24:0] ma, mb;
      ma = a[23] ? 25'(-{a[23], a}) : {1'b0, a};
      mb = b[23] ? 25'(-{b[23], b}) : {1'b0, b};
      return ma > mb;
   endfunction

   // reactive power, average and peaks
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         inst_q_q <= 24'h000000;
         avg_q_q <= 24'h000000;
         acc_q <= 48'h000000000000;
         ipeak_run_q <= 24'h000000;
         vpeak_run_q <= 24'h000000;
         ipeak_q <= 24'h000000;
         vpeak_q <= 24'h000000;
      end
      else if (sample.valid)
      begin
         inst_q_q <= prod[46:23];
         if (cycle_end)
         begin
            avg_q_q <= 24'((signed'(acc_q) + 48'(signed'(prod[46:23]))) / signed'(48'(n_eff)));
            acc_q <= 48'h000000000000;
            ipeak_q <= bigger(sample.current, ipeak_run_q) ? sample.current : ipeak_run_q;
            vpeak_q <= bigger(sample.voltage, vpeak_run_q) ? sample.voltage : vpeak_run_q;
            ipeak_run_q <= 24'h000000;
            vpeak_run_q <= 24'h000000;
         end
         else
         begin
            acc_q <= 48'(signed'(acc_q) + 48'(signed'(prod[46:23])));
            if (bigger(sample.current, ipeak_run_q))
               ipeak_run_q <= sample.current;
            if (bigger(sample.voltage, vpeak_run_q))
               vpeak_run_q <= sample.voltage;
         end
      end
   end

   // temperature result, signed 8.16 celsius
   always_ff @(posedge clk)
   begin
      if (!rstn)
         temp_q <= 24'h000000;
      else if (temp_valid)
         temp_q <= temp_celsius;
   end

   // decoded mode fields for the filter path
   always_comb
   begin
      path_ctrl.pulse_out_b_select = config_q[BIT_PULSE_OUT_B_SELECT];
      path_ctrl.voltage_extra_delay = config_q[BIT_VOLTAGE_EXTRA_DELAY];
      path_ctrl.current_extra_delay = config_q[BIT_CURRENT_EXTRA_DELAY];
      path_ctrl.current_dc_block = config_q[BIT_CURRENT_DC_BLOCK];
      path_ctrl.voltage_dc_block = config_q[BIT_VOLTAGE_DC_BLOCK];
      path_ctrl.current_all_pass = config_q[BIT_VOLTAGE_DC_BLOCK] && !config_q[BIT_CURRENT_DC_BLOCK];
      path_ctrl.voltage_all_pass = config_q[BIT_CURRENT_DC_BLOCK] && !config_q[BIT_VOLTAGE_DC_BLOCK];
      path_ctrl.comp_filter_enable = !config_q[BIT_COMP_FILTER_DISABLE];
      path_ctrl.pulse_out_c_select = pulse_c_sel_t'(config_q[BIT_PULSE_OUT_C_LO +: 2]);
      path_ctrl.positive_only = config_q[BIT_POSITIVE_ONLY];
      path_ctrl.auto_line_freq_track = config_q[BIT_AUTO_LINE_FREQ_TRACK];
   end

   // pulse output steering, registered
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         energy_pulse_out_a <= 1'b0;
         energy_pulse_out_b <= 1'b0;
         energy_pulse_out_c <= 1'b0;
      end
      else
      begin
         energy_pulse_out_a <= energy_pulse_raw && !(path_ctrl.positive_only && energy_negative);
         energy_pulse_out_b <= path_ctrl.pulse_out_b_select ? apparent_pulse_raw : energy_negative;
         unique case (path_ctrl.pulse_out_c_select)
            PULSE_C_REACTIVE: energy_pulse_out_c <= reactive_pulse_raw;
            PULSE_C_SUPPLY: energy_pulse_out_c <= supply_monitor_input;
            PULSE_C_VSIGN: energy_pulse_out_c <= sample.voltage[23];
            PULSE_C_APPARENT: energy_pulse_out_c <= apparent_pulse_raw;
         endcase
      end
   end

   // read channel, one-cycle answer
   logic [23:0] rd_word;
   always_comb
   begin
      ar_ok = 1'b1;
      rd_word = 24'h000000;
      unique case (s_axi_araddr[7:2])
         IDX_CURRENT_AC_TRIM: rd_word = current_ac_trim_q;
         IDX_VOLTAGE_AC_TRIM: rd_word = voltage_ac_trim_q;
         IDX_OPERATING_CONFIG: rd_word = config_q;
         IDX_TEMPERATURE_READING: rd_word = temp_q;
         IDX_AVG_REACTIVE_POWER: rd_word = avg_q_q;
         IDX_INST_REACTIVE_POWER: rd_word = inst_q_q;
         IDX_CURRENT_MAX_SAMPLE: rd_word = ipeak_q;
         IDX_VOLTAGE_MAX_SAMPLE: rd_word = vpeak_q;
         IDX_STATUS: rd_word = {calc_done_q, 22'h000000, cal_busy_q};
         IDX_COMMAND: rd_word = 24'h000000;
         IDX_CYCLE_COUNT: rd_word = cycle_count_q;
         default: ar_ok = 1'b0;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {8'h00, rd_word};
         s_axi_rresp <= ar_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule
`default_nettype wire

// ==== metering_regs_properties.sv ====
// checker: bus handshake, mode decode and pulse routing of the metering register bank
`default_nettype none
module metering_regs_properties
import metering_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire metering_pkg::sample_t sample,
   input wire logic energy_pulse_raw,
   input wire logic energy_negative,
   input wire logic apparent_pulse_raw,
   input wire logic reactive_pulse_raw,
   input wire logic supply_monitor_input,
   input wire metering_pkg::path_ctrl_t path_ctrl,
   input wire logic energy_pulse_out_a,
   input wire logic energy_pulse_out_b,
   input wire logic energy_pulse_out_c,
   input wire logic cycle_end
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // address and data of one write taken on the same edge
   sequence s_write_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_cfg_write;
      s_write_taken ##0 (s_axi_awaddr == 8'h48);
   endsequence
   // written mode bits show on the decoded field group
   property p_cfg_decode;
      logic [9:0] d;
      (s_cfg_write, d = s_axi_wdata[9:0]) |-> ##3
         {path_ctrl.pulse_out_b_select, path_ctrl.voltage_extra_delay, path_ctrl.current_extra_delay,
          path_ctrl.current_dc_block, path_ctrl.voltage_dc_block, !path_ctrl.comp_filter_enable,
          path_ctrl.pulse_out_c_select, path_ctrl.positive_only, path_ctrl.auto_line_freq_track} == d;
   endproperty
   // bus answers, mode decode and all-pass choice
   a_write_answer: assert property (s_write_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_cfg_decode: assert property (p_cfg_decode)
      else $error("mode decode mismatch");
   a_all_pass_pair: assert property (path_ctrl.current_all_pass ==
         (path_ctrl.voltage_dc_block && !path_ctrl.current_dc_block) &&
         path_ctrl.voltage_all_pass == (path_ctrl.current_dc_block && !path_ctrl.voltage_dc_block))
      else $error("all-pass choice wrong");
   // registered pulse routing, one cycle behind its sources; cycle end only on a sample strobe
   a_pulse_a_gate: assert property ($past(rstn) |-> energy_pulse_out_a ==
         $past(energy_pulse_raw && !(path_ctrl.positive_only && energy_negative)))
      else $error("pulse a mismatch");
   a_pulse_b_route: assert property ($past(rstn) |-> energy_pulse_out_b ==
         $past(path_ctrl.pulse_out_b_select ? apparent_pulse_raw : energy_negative))
      else $error("pulse b mismatch");
   a_pulse_c_react: assert property ($past(rstn) && $past(path_ctrl.pulse_out_c_select) == 2'b00 |->
         energy_pulse_out_c == $past(reactive_pulse_raw))
      else $error("pulse c reactive mismatch");
   a_pulse_c_other: assert property ($past(rstn) && $past(path_ctrl.pulse_out_c_select[0]) |->
         energy_pulse_out_c == $past(path_ctrl.pulse_out_c_select[1] ? apparent_pulse_raw : supply_monitor_input))
      else $error("pulse c source mismatch");
   a_cycle_end_sample: assert property (cycle_end |-> sample.valid)
      else $error("cycle end without sample");
endmodule
bind metering_regs metering_regs_properties chk (.*);
`default_nettype wire

// ==== metering_host_model.sv ====
// host model: axi4-lite master standing on the register bus side
`default_nettype none
module metering_host_model
(
   input wire logic clk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ns;
   // bus idle at time zero
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
   end
   // one write; entered just after a rising edge, ready sampled where settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      logic ta;
      logic tw;
      if (a == 8'h48 && d[8]) d[7] = 1'b0;
      ta = 1'b0;
      tw = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw))
      begin
         @(negedge clk);
         ta = ta || s_axi_awready;
         tw = tw || s_axi_wready;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      do @(negedge clk); while (!s_axi_bvalid);
      resp = s_axi_bresp;
      @(posedge clk);
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask
   // one read
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge clk); while (!s_axi_arready);
      @(posedge clk);
      s_axi_arvalid <= 1'b0;
      do @(negedge clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ==== metering_regs_tb_top.sv ====
// testbench: registers, mode decode, pulse routing, results and calibration
`default_nettype none
module metering_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import metering_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cycle_end;
   logic energy_pulse_out_a, energy_pulse_out_b, energy_pulse_out_c;
   logic temp_valid = 1'b0;
   logic [23:0] temp_celsius = 24'h000000;
   logic energy_pulse_raw = 1'b0, energy_negative = 1'b0, apparent_pulse_raw = 1'b0;
   logic reactive_pulse_raw = 1'b0, supply_monitor_input = 1'b0;
   sample_t sample = '0;
   path_ctrl_t path_ctrl;
   int n_mismatch = 0, compares = 0, cyc = 0, n_end = 0;
   metering_regs dut (.*);
   metering_host_model host (.*);
   always #25 clk = ~clk;
   // cycle ceiling against a hung handshake; counts computation cycle ends
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cycle_end) n_end <= n_end + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // comparisons of data words and of response codes
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t resp %b want %b", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      host.rd(a, rdat, rsp);
      chk(rdat, exp);
      chk_rsp(rsp, er);
   endtask
   task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      host.wr(a, d, rsp);
      chk_rsp(rsp, er);
   endtask
   // status: done flag and calibration busy
   task automatic stat(input logic done, input logic busy);
      host.rd(8'h80, rdat, rsp);
      chk({30'h0, rdat[23], rdat[0]}, {30'h0, done, busy});
   endtask
   // one adc sample strobe, then three idle cycles
   task automatic smp(input logic [23:0] c, input logic [23:0] v, input logic [23:0] s);
      sample <= {1'b1, c, v, s};
      @(posedge clk);
      sample.valid <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   function automatic path_ctrl_t dec(input logic [9:0] c);
      return {c[9], c[8], c[7], c[6], c[5], c[5] & ~c[6], c[6] & ~c[5], ~c[4], c[3:2], c[1], c[0]};
   endfunction
   task automatic t_regs();
      rdc(8'h40, 32'h0, RESP_OKAY);
      rdc(8'h44, 32'h0, RESP_OKAY);
      rdc(8'hfc, 32'h0, RESP_SLVERR);
      wrc(8'h4c, 32'h00123456, RESP_SLVERR);
      wrc(8'h40, 32'h00800000, RESP_OKAY);
      rdc(8'h40, 32'h00800000, RESP_OKAY);
      wrc(8'h44, 32'hff7fffff, RESP_OKAY);
      rdc(8'h44, 32'h007fffff, RESP_OKAY);
      $display("test regs done");
   endtask
   task automatic t_mode();
      logic [9:0] m [12] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h020, 10'h060, 10'h010, 10'h004,
                             10'h008, 10'h00c, 10'h002, 10'h001};
      rdc(8'h48, 32'h0, RESP_OKAY);
      foreach (m[i])
      begin
         wrc(8'h48, {22'h0, m[i]}, RESP_OKAY);
         rdc(8'h48, {22'h0, m[i]}, RESP_OKAY);
         chk({20'h0, path_ctrl}, {20'h0, dec(m[i])});
      end
      $display("test mode done");
   endtask
   task automatic t_pulse();
      {energy_pulse_raw, energy_negative, apparent_pulse_raw, reactive_pulse_raw, supply_monitor_input} <= 5'b11010;
      sample.voltage <= 24'h800000;
      for (int s = 0; s < 4; s++)
      begin
         wrc(8'h48, {22'h0, s[0], 5'h0, s[1:0], s[1], 1'b0}, RESP_OKAY);
         repeat (2) @(posedge clk);
         @(negedge clk);
         chk({29'h0, energy_pulse_out_a, energy_pulse_out_b, energy_pulse_out_c},
             {29'h0, !s[1], !s[0], s == 0 || s == 2});
         @(posedge clk);
      end
      wrc(8'h48, 32'h0, RESP_OKAY);
      $display("test pulse done");
   endtask
   task automatic t_result();
      logic [23:0] c [4] = '{24'h100000, 24'hd00000, 24'h200000, 24'h050000};
      logic [23:0] v [4] = '{24'h080000, 24'h070000, 24'hf00000, 24'h0c0000};
      wrc(8'h88, 32'h4, RESP_OKAY);
      foreach (c[i]) smp(c[i], v[i], 24'h400000);
      rdc(8'h54, 32'h00028000, RESP_OKAY);
      rdc(8'h50, 32'h0000a000, RESP_OKAY);
      rdc(8'h58, 32'h00d00000, RESP_OKAY);
      rdc(8'h5c, 32'h00f00000, RESP_OKAY);
      stat(1'b1, 1'b0);
      wrc(8'h80, 32'h00800000, RESP_OKAY);
      stat(1'b0, 1'b0);
      repeat (4) smp(24'h010000, 24'h020000, 24'h000000);
      rdc(8'h58, 32'h00010000, RESP_OKAY);
      rdc(8'h5c, 32'h00020000, RESP_OKAY);
      rdc(8'h50, 32'h0, RESP_OKAY);
      chk(n_end, 32'd2);
      wrc(8'h80, 32'h00800000, RESP_OKAY);
      temp_celsius <= 24'he78000;
      temp_valid <= 1'b1;
      @(posedge clk);
      temp_valid <= 1'b0;
      rdc(8'h4c, 32'h00e78000, RESP_OKAY);
      $display("test result done");
   endtask
   task automatic t_cal();
      wrc(8'h84, 32'h1, RESP_OKAY);
      repeat (53) smp(24'h001000, 24'h002000, 24'h000000);
      stat(1'b0, 1'b1);
      smp(24'h001000, 24'h002000, 24'h000000);
      stat(1'b1, 1'b0);
      rdc(8'h40, 32'h00fff000, RESP_OKAY);
      rdc(8'h44, 32'h00ffe000, RESP_OKAY);
      chk(n_end, 32'd2);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rdc(8'h40, 32'h0, RESP_OKAY);
      wrc(8'h48, 32'h80, RESP_OKAY);
      smp(24'h100000, 24'h0, 24'h400000);
      smp(24'h200000, 24'h0, 24'h400000);
      rdc(8'h54, 32'h00080000, RESP_OKAY);
      wrc(8'h48, 32'h100, RESP_OKAY);
      smp(24'h200000, 24'h0, 24'h200000);
      smp(24'h200000, 24'h0, 24'h400000);
      rdc(8'h54, 32'h00080000, RESP_OKAY);
      $display("test cal done");
   endtask
   // reset for two cycles, then the tests in turn
   initial
   begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_regs();
      t_mode();
      t_pulse();
      t_result();
      t_cal();
      stop_test();
   end
endmodule
`default_nettype wire
